// *** hw/event_counter_pkg.sv ***
// constants, encodings and register map of the selectable event counter block
package event_counter_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_COUNTERS = 2;
    localparam int IDX_W        = 1;
    localparam int CNT_W        = 32;
    localparam int SEL_W        = 5;
    localparam int ACT_W        = 3;
    localparam int SRC_W        = 32;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 32;
    localparam int BE_W         = 4;
    localparam int NUM_EVENTS   = 8;
    localparam int NUM_PINS     = 4;
    localparam int NUM_USER     = 4;
    localparam int NUM_TIMERS   = 2;
    localparam int NUM_ACTIONS  = 2;

    localparam logic [CNT_W-1:0] CNT_MAX  = 32'hFFFFFFFF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h00000000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 32'h00000001;

    // ------------------------------------------------------------------
    // source selection codes, one bit of the source vector each
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0] SRC_OFF         = 5'h00;
    localparam logic [SEL_W-1:0] SRC_OWN_START   = 5'h01;
    localparam int               SRC_EVENT_BASE  = 2;
    localparam int               SRC_PIN_BASE    = 10;
    localparam int               SRC_USER_BASE   = 14;
    localparam int               SRC_CNT_END_BASE = 18;
    localparam int               SRC_TIMER_BASE  = 20;
    localparam int               SRC_ACTION_BASE = 22;
    localparam int               SRC_TICK        = 24;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_INDEX_SELECT   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_COUNT_SOURCE   = 8'h04;
    localparam logic [ADDR_W-1:0] REG_COUNT_EDGE     = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CLEAR_SOURCE   = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_CLEAR_ACT      = 8'h10;
    localparam logic [ADDR_W-1:0] REG_SW_CLEAR       = 8'h14;
    localparam logic [ADDR_W-1:0] REG_CURRENT_COUNT  = 8'h18;
    localparam logic [ADDR_W-1:0] REG_CAPTURED       = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_TERMINAL_COUNT = 8'h20;
    localparam logic [ADDR_W-1:0] REG_COUNT_STATE    = 8'h24;
    localparam logic [ADDR_W-1:0] REG_START_SOURCE   = 8'h28;
    localparam logic [ADDR_W-1:0] REG_START_ACT      = 8'h2C;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    typedef enum logic [ACT_W-1:0] {
        upward_transition   = 3'h0,
        downward_transition = 3'h1,
        either_transition   = 3'h2,
        while_asserted_high = 3'h3,
        while_asserted_low  = 3'h4
    } activation_type;

    typedef enum logic [1:0] {
        PH_WAIT = 2'h0,
        PH_RUN  = 2'h1,
        PH_DONE = 2'h2
    } phase_type;

    typedef enum logic [2:0] {
        state_idle        = 3'h0,
        state_await_start = 3'h1,
        state_active      = 3'h2,
        state_done        = 3'h3,
        state_saturated   = 3'h4
    } count_state_type;

    localparam logic [ACT_W-1:0] ACT_RESET   = 3'h0;
    localparam logic [SEL_W-1:0] SEL_RESET   = 5'h00;
    localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h00000000;

endpackage

// *** hw/event_counter.sv ***
// selectable event counters with clear, start and terminal count, Avalon-MM slave
`timescale 1ns/100ps
module event_counter
(
    input  wire logic                                   clk_sys_i,
    input  wire logic                                   reset_n_i,
    input  wire logic [event_counter_pkg::ADDR_W-1:0]   avs_address_i,
    input  wire logic                                   avs_read_i,
    input  wire logic                                   avs_write_i,
    input  wire logic [event_counter_pkg::DATA_W-1:0]   avs_writedata_i,
    input  wire logic [event_counter_pkg::BE_W-1:0]     avs_byteenable_i,
    output logic [event_counter_pkg::DATA_W-1:0]        avs_readdata_o,
    output logic                                        avs_waitrequest_o,
    input  wire logic [event_counter_pkg::NUM_EVENTS-1:0]  internal_event_i,
    input  wire logic [event_counter_pkg::NUM_PINS-1:0]    io_pin_i,
    input  wire logic [event_counter_pkg::NUM_USER-1:0]    sw_output_bit_i,
    input  wire logic [event_counter_pkg::NUM_TIMERS-1:0]  timer_done_i,
    input  wire logic [event_counter_pkg::NUM_ACTIONS-1:0] broadcast_action_i,
    input  wire logic                                      timestamp_tick_i,
    output logic [event_counter_pkg::NUM_COUNTERS-1:0]  terminal_reached_event_o,
    output logic [event_counter_pkg::NUM_COUNTERS-1:0]  count_running_signal_o
);
    import event_counter_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic act_hit(input logic [ACT_W-1:0] act, input logic cur,
                                     input logic prev);
        logic hit;
        hit = 1'b0;
        case (act)
            upward_transition:   hit = cur & ~prev;
            downward_transition: hit = ~cur & prev;
            either_transition:   hit = cur ^ prev;
            while_asserted_high: hit = cur;
            while_asserted_low:  hit = ~cur;
            default:             hit = 1'b0;
        endcase
        return hit;
    endfunction

    // entry into the active condition, used to start from the done phase and, for edge activations, from the wait phase
    function automatic logic act_entry(input logic [ACT_W-1:0] act, input logic cur,
                                       input logic prev);
        logic hit;
        hit = 1'b0;
        case (act)
            while_asserted_high: hit = cur & ~prev;
            while_asserted_low:  hit = ~cur & prev;
            default:             hit = act_hit(act, cur, prev);
        endcase
        return hit;
    endfunction

    function automatic logic is_level(input logic [ACT_W-1:0] act);
        return (act == while_asserted_high) || (act == while_asserted_low);
    endfunction

    function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [BE_W-1:0]   be);
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int b = 0; b < BE_W; b++)
        begin
            if (be[b])
            begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_s1_q;
    logic [NUM_PINS-1:0] pin_s2_q;
    logic [NUM_PINS-1:0] pin_s3_q;
    logic [NUM_PINS-1:0] pin_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
            pin_q    <= '0;
        end
        else
        begin
            pin_s1_q <= io_pin_i;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            for (int p = 0; p < NUM_PINS; p++)
            begin
                if (pin_s2_q[p] == pin_s3_q[p])
                begin
                    pin_q[p] <= pin_s3_q[p];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // bus slave handshake
    // ------------------------------------------------------------------
    logic              wait_q;
    logic              acc_wr;
    logic              idx_q;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] readdata_q;

    assign acc_wr            = avs_write_i & ~wait_q;
    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o    = readdata_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            wait_q <= 1'b1;
        end
        else
        begin
            wait_q <= ~((avs_read_i | avs_write_i) & wait_q);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            readdata_q <= WORD_ZERO;
        end
        else if (avs_read_i && wait_q)
        begin
            readdata_q <= rd_word;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            idx_q <= 1'b0;
        end
        else if (acc_wr && avs_address_i == REG_INDEX_SELECT && avs_byteenable_i[0]
                 && avs_writedata_i < DATA_W'(NUM_COUNTERS))
        begin
            idx_q <= avs_writedata_i[IDX_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // per-counter storage
    // ------------------------------------------------------------------
    logic [SEL_W-1:0] src_sel_q   [NUM_COUNTERS];
    logic [ACT_W-1:0] edge_sel_q  [NUM_COUNTERS];
    logic [SEL_W-1:0] clr_src_q   [NUM_COUNTERS];
    logic [ACT_W-1:0] clr_act_q   [NUM_COUNTERS];
    logic [SEL_W-1:0] st_src_q    [NUM_COUNTERS];
    logic [ACT_W-1:0] st_act_q    [NUM_COUNTERS];
    logic [CNT_W-1:0] term_q      [NUM_COUNTERS];
    logic [CNT_W-1:0] count_q     [NUM_COUNTERS];
    logic [CNT_W-1:0] capt_q      [NUM_COUNTERS];
    phase_type        phase_q     [NUM_COUNTERS];
    logic             done_q      [NUM_COUNTERS];
    logic             running_q   [NUM_COUNTERS];
    count_state_type  state_rpt   [NUM_COUNTERS];
    logic [SRC_W-1:0] common_vec;

    always_comb
    begin
        common_vec = '0;
        common_vec[SRC_EVENT_BASE +: NUM_EVENTS]   = internal_event_i;
        common_vec[SRC_PIN_BASE +: NUM_PINS]       = pin_q;
        common_vec[SRC_USER_BASE +: NUM_USER]      = sw_output_bit_i;
        common_vec[SRC_TIMER_BASE +: NUM_TIMERS]   = timer_done_i;
        common_vec[SRC_ACTION_BASE +: NUM_ACTIONS] = broadcast_action_i;
        common_vec[SRC_TICK]                       = timestamp_tick_i;
        for (int c = 0; c < NUM_COUNTERS; c++)
        begin
            common_vec[SRC_CNT_END_BASE + c] = done_q[c];
        end
    end

    // ------------------------------------------------------------------
    // counters
    // ------------------------------------------------------------------
    for (genvar k = 0; k < NUM_COUNTERS; k++)
    begin : g_cnt
        logic [SRC_W-1:0] vec;
        logic             cnt_prev_q;
        logic             clr_prev_q;
        logic             st_prev_q;
        logic             clr_seen_q;
        logic             cnt_hit;
        logic             clr_hit;
        logic             st_cfg;
        logic             st_ok;
        logic             st_trig;
        logic             counting;
        logic             wr_k;
        logic             swclr_k;
        logic [CNT_W-1:0] inc;
        logic [DATA_W-1:0] wmerge;

        assign wr_k    = acc_wr && (idx_q == IDX_W'(k));
        assign swclr_k = wr_k && avs_address_i == REG_SW_CLEAR;
        assign inc     = count_q[k] + CNT_ONE;

        always_comb
        begin
            vec                = common_vec;
            vec[SRC_OWN_START] = common_vec[st_src_q[k]];
            wmerge             = be_merge(count_q[k], avs_writedata_i, avs_byteenable_i);
            cnt_hit = (src_sel_q[k] != SRC_OFF)
                      && act_hit(edge_sel_q[k], vec[src_sel_q[k]], cnt_prev_q);
            clr_hit = (clr_src_q[k] != SRC_OFF)
                      && act_hit(clr_act_q[k], vec[clr_src_q[k]], clr_prev_q);
            st_cfg  = st_src_q[k] != SRC_OFF;
            st_ok   = !st_cfg || !is_level(st_act_q[k])
                      || act_hit(st_act_q[k], vec[st_src_q[k]], st_prev_q);
            st_trig = st_cfg && act_entry(st_act_q[k], vec[st_src_q[k]], st_prev_q);
            counting = phase_q[k] == PH_RUN && st_ok && src_sel_q[k] != SRC_OFF;
        end

        // configuration writes
        always_ff @(posedge clk_sys_i or negedge rst_n_q)
        begin
            if (!rst_n_q)
            begin
                src_sel_q[k]  <= SEL_RESET;
                edge_sel_q[k] <= ACT_RESET;
                clr_src_q[k]  <= SEL_RESET;
                clr_act_q[k]  <= ACT_RESET;
                st_src_q[k]   <= SEL_RESET;
                st_act_q[k]   <= ACT_RESET;
                term_q[k]     <= CNT_ZERO;
            end
            else if (wr_k && avs_byteenable_i[0])
            begin
                case (avs_address_i)
                    REG_COUNT_SOURCE: src_sel_q[k]  <= avs_writedata_i[SEL_W-1:0];
                    REG_COUNT_EDGE:   edge_sel_q[k] <= avs_writedata_i[ACT_W-1:0];
                    REG_CLEAR_SOURCE: clr_src_q[k]  <= avs_writedata_i[SEL_W-1:0];
                    REG_CLEAR_ACT:    clr_act_q[k]  <= avs_writedata_i[ACT_W-1:0];
                    REG_START_SOURCE: st_src_q[k]   <= avs_writedata_i[SEL_W-1:0];
                    REG_START_ACT:    st_act_q[k]   <= avs_writedata_i[ACT_W-1:0];
                    REG_TERMINAL_COUNT: term_q[k]   <= be_merge(term_q[k], avs_writedata_i,
                                                                avs_byteenable_i);
                    default: ;
                endcase
            end
            else if (wr_k && avs_address_i == REG_TERMINAL_COUNT)
            begin
                term_q[k] <= be_merge(term_q[k], avs_writedata_i, avs_byteenable_i);
            end
        end

        // previous source levels for edge detection
        always_ff @(posedge clk_sys_i or negedge rst_n_q)
        begin
            if (!rst_n_q)
            begin
                cnt_prev_q <= 1'b0;
                clr_prev_q <= 1'b0;
                st_prev_q  <= 1'b0;
                clr_seen_q <= 1'b0;
            end
            else
            begin
                cnt_prev_q <= vec[src_sel_q[k]];
                clr_prev_q <= vec[clr_src_q[k]];
                st_prev_q  <= vec[st_src_q[k]];
                clr_seen_q <= clr_hit;
            end
        end

        // count, capture and phase
        always_ff @(posedge clk_sys_i or negedge rst_n_q)
        begin
            if (!rst_n_q)
            begin
                count_q[k] <= CNT_ZERO;
                capt_q[k]  <= CNT_ZERO;
                phase_q[k] <= PH_WAIT;
                done_q[k]  <= 1'b0;
            end
            else
            begin
                done_q[k] <= 1'b0;
                if (swclr_k)
                begin
                    count_q[k] <= CNT_ZERO;
                    capt_q[k]  <= count_q[k];
                    phase_q[k] <= st_cfg ? PH_WAIT : PH_RUN;
                end
                else if (clr_hit)
                begin
                    count_q[k] <= CNT_ZERO;
                    if (!clr_seen_q)
                    begin
                        capt_q[k] <= count_q[k];
                    end
                end
                else if (wr_k && avs_address_i == REG_CURRENT_COUNT)
                begin
                    count_q[k] <= wmerge;
                end
                else
                begin
                    unique case (phase_q[k])
                        PH_WAIT:
                        begin
                            if (!st_cfg || (is_level(st_act_q[k]) ? st_ok : st_trig))
                            begin
                                phase_q[k] <= PH_RUN;
                            end
                        end
                        PH_RUN:
                        begin
                            if (counting && cnt_hit && count_q[k] != CNT_MAX)
                            begin
                                count_q[k] <= inc;
                                if (term_q[k] != CNT_ZERO && inc == term_q[k])
                                begin
                                    phase_q[k] <= PH_DONE;
                                    done_q[k]  <= 1'b1;
                                end
                            end
                        end
                        PH_DONE:
                        begin
                            if (st_trig)
                            begin
                                capt_q[k]  <= count_q[k];
                                count_q[k] <= CNT_ZERO;
                                phase_q[k] <= PH_RUN;
                            end
                        end
                        default: phase_q[k] <= PH_WAIT;
                    endcase
                end
            end
        end

        always_ff @(posedge clk_sys_i or negedge rst_n_q)
        begin
            if (!rst_n_q)
            begin
                running_q[k] <= 1'b0;
            end
            else
            begin
                running_q[k] <= counting;
            end
        end

        // reported state
        always_comb
        begin
            if (src_sel_q[k] == SRC_OFF)
            begin
                state_rpt[k] = state_idle;
            end
            else if (count_q[k] == CNT_MAX)
            begin
                state_rpt[k] = state_saturated;
            end
            else if (phase_q[k] == PH_DONE)
            begin
                state_rpt[k] = state_done;
            end
            else if (phase_q[k] == PH_RUN && st_ok)
            begin
                state_rpt[k] = state_active;
            end
            else
            begin
                state_rpt[k] = state_await_start;
            end
        end

        assign terminal_reached_event_o[k] = done_q[k];
        assign count_running_signal_o[k]   = running_q[k];
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_word = WORD_ZERO;
        case (avs_address_i)
            REG_INDEX_SELECT:   rd_word = DATA_W'(idx_q);
            REG_COUNT_SOURCE:   rd_word = DATA_W'(src_sel_q[idx_q]);
            REG_COUNT_EDGE:     rd_word = DATA_W'(edge_sel_q[idx_q]);
            REG_CLEAR_SOURCE:   rd_word = DATA_W'(clr_src_q[idx_q]);
            REG_CLEAR_ACT:      rd_word = DATA_W'(clr_act_q[idx_q]);
            REG_SW_CLEAR:       rd_word = WORD_ZERO;
            REG_CURRENT_COUNT:  rd_word = count_q[idx_q];
            REG_CAPTURED:       rd_word = capt_q[idx_q];
            REG_TERMINAL_COUNT: rd_word = term_q[idx_q];
            REG_COUNT_STATE:    rd_word = DATA_W'(state_rpt[idx_q]);
            REG_START_SOURCE:   rd_word = DATA_W'(st_src_q[idx_q]);
            REG_START_ACT:      rd_word = DATA_W'(st_act_q[idx_q]);
            default:            rd_word = WORD_ZERO;
        endcase
    end

endmodule

// *** sim/event_counter_chk.sv ***
// port checker for the event counter bus and terminal behaviour
`timescale 1ns/100ps
module event_counter_chk (
    input wire logic        clk_sys_i,
    input wire logic        reset_n_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [1:0]  terminal_reached_event_o,
    input wire logic [1:0]  count_running_signal_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("wait low too long");
    a_idle_no_answer: assert property (!(avs_read_i || avs_write_i) |=>
        avs_waitrequest_o) else $error("answer without request");
    a_req_answered: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered");
    a_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
        else $error("read data moved");
    a_cmd_reads_zero: assert property (avs_read_i && avs_waitrequest_o &&
        (avs_address_i == 8'h14 || avs_address_i > 8'h2C) |=> avs_readdata_o == 32'h0)
        else $error("command or hole not zero");
    a_end_one_pulse: assert property ((terminal_reached_event_o &
        $past(terminal_reached_event_o)) == 2'b00) else $error("end pulse too long");
    a_end_stops_run: assert property (terminal_reached_event_o[0] |->
        ##[1:2] !count_running_signal_o[0]) else $error("running stays high");
    a_end_from_run: assert property ($rose(terminal_reached_event_o[0]) |->
        count_running_signal_o[0]) else $error("end while not running");
endmodule
bind event_counter event_counter_chk i_event_counter_chk (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .terminal_reached_event_o(terminal_reached_event_o),
    .count_running_signal_o(count_running_signal_o));

// *** sim/tb_event_counter.sv ***
// self-checking bench of the event counter
`timescale 1ns/100ps
module tb_event_counter;
    import event_counter_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        rd_en = 1'b0, wr_en = 1'b0, waitr;
    logic [7:0]  addr = 8'h00;
    logic [10:0] ev = 11'h000;
    logic [1:0]  tre, run;
    logic [31:0] wdata = 32'h0, rdata, got;
    int          fails = 0, checks_done = 0, ends = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    event_counter i_event_counter (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(waitr),
        .internal_event_i(ev[7:0]), .io_pin_i(4'h0), .sw_output_bit_i({3'h0, ev[10]}),
        .timer_done_i(2'h0), .broadcast_action_i(ev[9:8]), .timestamp_tick_i(1'b0),
        .terminal_reached_event_o(tre), .count_running_signal_o(run));
    always @(posedge clk_sys_i)
        if (tre[0] === 1'b1) ends++;
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) fails++;
        if (s !== e) $display("FAIL %s expected %h seen %h", n, e, s);
    endtask
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        {wr_en, rd_en, addr, wdata} <= {w, ~w, a, d};
        do @(posedge clk_sys_i); while (waitr !== 1'b0);
        {wr_en, rd_en} <= 2'b00;
        got = rdata;
    endtask
    task rd(input logic [7:0] a, input string n, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(n, got, e);
    endtask
    task tog(input int k, input int n);
        repeat (n) @(posedge clk_sys_i) ev[k] <= ~ev[k];
    endtask
    task s_edges;
        acc(1'b1, REG_COUNT_SOURCE, 32'h2);
        for (int a = 0; a < 3; a++)
        begin
            acc(1'b1, REG_COUNT_EDGE, 32'(a));
            acc(1'b1, REG_CURRENT_COUNT, 32'h5);
            tog(0, 4);
            rd(REG_CURRENT_COUNT, "count", (a == 2) ? 32'h9 : 32'h7);
        end
    endtask
    task s_swclr;
        acc(1'b1, REG_SW_CLEAR, 32'h1);
        rd(REG_CAPTURED, "captured", 32'h9);
        rd(REG_CURRENT_COUNT, "count", 32'h0);
        rd(REG_SW_CLEAR, "clear cmd", 32'h0);
        acc(1'b1, REG_CAPTURED, 32'h55);
        rd(REG_CAPTURED, "captured", 32'h9);
        tog(0, 2);
        rd(REG_CURRENT_COUNT, "count", 32'h2);
    endtask
    task s_hwclr;
        tog(8, 2);
        rd(REG_CURRENT_COUNT, "count", 32'h2);
        acc(1'b1, REG_CLEAR_SOURCE, 32'h16);
        acc(1'b1, REG_CLEAR_ACT, 32'h0);
        tog(8, 2);
        rd(REG_CURRENT_COUNT, "count", 32'h0);
        rd(REG_CAPTURED, "captured", 32'h2);
    endtask
    task s_term;
        acc(1'b1, REG_COUNT_EDGE, 32'h0);
        acc(1'b1, REG_TERMINAL_COUNT, 32'h3);
        acc(1'b1, REG_SW_CLEAR, 32'h1);
        tog(0, 2);
        rd(REG_COUNT_STATE, "state", 32'h2);
        chk("running", 32'(run[0]), 32'h1);
        tog(0, 6);
        rd(REG_CURRENT_COUNT, "count", 32'h3);
        rd(REG_COUNT_STATE, "state", 32'h3);
        chk("running", 32'(run[0]), 32'h0);
        chk("end pulses", 32'(ends), 32'h1);
    endtask
    task s_sat;
        acc(1'b1, REG_TERMINAL_COUNT, 32'h0);
        acc(1'b1, REG_SW_CLEAR, 32'h1);
        acc(1'b1, REG_CURRENT_COUNT, CNT_MAX);
        tog(0, 2);
        rd(REG_CURRENT_COUNT, "count", CNT_MAX);
        rd(REG_COUNT_STATE, "state", 32'h4);
        acc(1'b1, REG_COUNT_SOURCE, 32'h0);
        rd(REG_COUNT_STATE, "state", 32'h0);
        acc(1'b1, REG_INDEX_SELECT, 32'h1);
        rd(REG_CURRENT_COUNT, "other count", 32'h0);
    endtask
    task s_start;
        acc(1'b1, REG_COUNT_SOURCE, 32'h2);
        acc(1'b1, REG_START_SOURCE, 32'h3);
        acc(1'b1, REG_START_ACT, 32'h3);
        acc(1'b1, REG_SW_CLEAR, 32'h1);
        rd(REG_COUNT_STATE, "state", 32'h1);
        tog(0, 2);
        rd(REG_CURRENT_COUNT, "count", 32'h0);
        @(posedge clk_sys_i) ev[1] <= 1'b1;
        tog(0, 2);
        rd(REG_CURRENT_COUNT, "count", 32'h1);
        acc(1'b1, REG_CLEAR_SOURCE, 32'hE);
        acc(1'b1, REG_CLEAR_ACT, 32'h3);
        @(posedge clk_sys_i) ev[10] <= 1'b1;
        tog(0, 2);
        rd(REG_CURRENT_COUNT, "count", 32'h0);
        rd(REG_CAPTURED, "captured", 32'h1);
    endtask
    task wrap_up;
        if (fails == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        s_edges;
        s_swclr;
        s_hwclr;
        s_term;
        s_sat;
        s_start;
        wrap_up;
    end
    initial
    begin
        #100000;
        fails++;
        wrap_up;
    end
endmodule
